// ===== hdl/panel_pkg.sv
// Shared constants, field layouts and carrier types of the panel key and
// output router. Assumes a 100 MHz system clock.
package panel_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RUN_HOLD_S    = 1;
  localparam int STOP_HOLD_S   = 2;
  localparam int MENU_HOLD_S   = 1;
  localparam int INHIBIT_S     = 5;
  localparam int RUN_HOLD_MS   = RUN_HOLD_S * 1000;
  localparam int STOP_HOLD_MS  = STOP_HOLD_S * 1000;
  localparam int MENU_HOLD_MS  = MENU_HOLD_S * 1000;
  localparam int INHIBIT_MS    = INHIBIT_S * 1000;
  localparam int DEBOUNCE_MS   = 20;
  localparam int BLINK_MS      = 500;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] ASSIGN_OFS   = 8'h04;
  localparam logic [7:0] XLO_OFS      = 8'h08;
  localparam logic [7:0] XHI_OFS      = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] VALUE_OFS    = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
  localparam logic [7:0] XOUT_OFS     = 8'h20;

  // Control register fields
  localparam int CTRL_PP_BIT    = 0;
  localparam int CTRL_HC_BIT    = 1;
  localparam int CTRL_LIN_BIT   = 2;
  localparam int CTRL_INSEL_LSB = 3;
  localparam int CTRL_EVSEL_LSB = 5;
  localparam int CTRL_XSRC_LSB  = 8;
  localparam int ASSIGN_W       = 4;

  // Reset values
  localparam logic [10:0] CTRL_RST   = 11'h000;
  localparam logic [15:0] ASSIGN_RST = 16'h4320;
  localparam logic [15:0] XLO_RST    = 16'h0000;
  localparam logic [15:0] XHI_RST    = 16'hffff;

  // Output function indices
  localparam int FN_HEAT  = 0;
  localparam int FN_COOL  = 1;
  localparam int FN_HBA   = 5;
  localparam int FN_LBA   = 6;
  localparam int FN_COUNT = 13;

  // Measurement, event and transfer source codes
  localparam logic [1:0] IN_TEMP    = 2'h0;
  localparam logic [1:0] IN_CURRENT = 2'h1;
  localparam logic [1:0] IN_VOLTAGE = 2'h2;
  localparam logic [2:0] EV_RUN     = 3'h0;
  localparam logic [2:0] EV_AUTO    = 3'h1;
  localparam logic [2:0] EV_HOLD    = 3'h2;
  localparam logic [2:0] EV_ADV     = 3'h3;
  localparam logic [2:0] EV_PAT     = 3'h4;
  localparam logic [2:0] XS_SP      = 3'h0;
  localparam logic [2:0] XS_PV      = 3'h1;
  localparam logic [2:0] XS_MVH     = 3'h2;
  localparam logic [2:0] XS_MVC     = 3'h3;
  localparam logic [2:0] XS_VALVE   = 3'h4;

  // Interrupt bits and key indices
  localparam int IRQ_RUN   = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_PARAM = 2;
  localparam int IRQ_MENU  = 3;
  localparam int IRQ_UP    = 4;
  localparam int IRQ_DOWN  = 5;
  localparam int IRQ_EVENT = 6;
  localparam int IRQ_READY = 7;
  localparam int IRQ_W     = 8;
  localparam int KEY_RUN   = 0;
  localparam int KEY_MODE  = 1;
  localparam int KEY_UP    = 2;
  localparam int KEY_DOWN  = 3;
  localparam int KEY_EVENT = 4;
  localparam int NKEY      = 5;

  typedef enum logic {ST_RESET, ST_RUN} run_state_type;

  typedef struct packed {
    logic [FN_COUNT-1:0] funcs;
    logic                valve_open;
    logic                valve_close;
    logic                manual;
    logic                remote;
    logic                autotune;
    logic                hold;
    logic                waiting;
  } proc_status_type;

  typedef struct packed {
    logic [15:0] sp;
    logic [15:0] pv;
    logic [15:0] mv_heat;
    logic [15:0] mv_cool;
    logic [15:0] valve;
  } xfer_src_type;

  typedef struct packed {
    logic ctrl1;
    logic ctrl2;
    logic aux1;
    logic aux2;
  } out_type;

  typedef struct packed {
    logic primary_control_lamp;
    logic secondary_control_lamp;
    logic first_auxiliary_lamp;
    logic second_auxiliary_lamp;
    logic manual_lamp;
    logic reset_lamp;
    logic remote_lamp;
    logic autotune_lamp;
    logic hold_lamp;
    logic wait_lamp;
  } lamp_type;

  typedef struct packed {
    logic run_reset;
    logic auto_manual;
    logic hold;
    logic advance;
    logic pattern;
  } event_route_type;

  typedef struct packed {
    logic [NKEY-1:0]      s1;
    logic [NKEY-1:0]      s2;
    logic [NKEY-1:0]      s3;
    logic [NKEY-1:0]      deb;
    logic [NKEY-1:0][7:0] deb_ms;
    logic [31:0]          tick_cnt;
    logic [15:0]          run_ms;
    logic                 run_done;
    logic [15:0]          mode_ms;
    logic                 mode_done;
    logic [15:0]          inhibit_ms;
    logic                 ready;
    logic [15:0]          blink_ms;
    logic                 blink;
    run_state_type        run_state;
    logic                 menu;
    logic [7:0]           param_idx;
    logic [15:0]          value;
    logic [10:0]          ctrl;
    logic [15:0]          assign_map;
    logic [15:0]          xlo;
    logic [15:0]          xhi;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic                 irq;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic [15:0]          meas;
    logic [15:0]          transfer;
    logic                 ct_enable;
    out_type              outs;
    lamp_type             lamps;
    event_route_type      evr;
  } state_type;

endpackage

// ===== hdl/panel_keys_output_router.sv
// Front-panel key decoder, indicator driver, output router and transfer
// output scaler with an AHB-Lite register slave.
// Assumes key and event pins are asynchronous and active high when pressed;
// process status and values come from logic on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Run after run key held one second
// - Reset after run key held two seconds
// - Short mode press advances; long shows menu
// - Up/down keys step the shown value
// - Output lamps follow their routed functions
// - Manual, reset, remote lamps; autotune lamp flashes
// - Hold and wait lamps follow program status
// - One measurement source selected by configuration
// - Event input routed to one of five
// - All outputs inactive five seconds after power-up
// - Thirteen functions routable to four outputs
// - Valve variant: fixed valve outputs, heat, cool, HBA and LBA functions disabled
// - Linear output unit disables current transformer input
// - Heating/cooling drives heat and cool outputs
// - Five transfer sources, variant dependent
// - Transfer scaling between limits, reversible
module panel_keys_output_router
  import panel_pkg::*;
#(
  parameter int TICK_CYCLES   = panel_pkg::CYCLES_PER_MS,
  parameter int RUN_HOLD_LIM  = panel_pkg::RUN_HOLD_MS,
  parameter int STOP_HOLD_LIM = panel_pkg::STOP_HOLD_MS,
  parameter int MENU_HOLD_LIM = panel_pkg::MENU_HOLD_MS,
  parameter int INHIBIT_LIM   = panel_pkg::INHIBIT_MS,
  parameter int DEBOUNCE_LIM  = panel_pkg::DEBOUNCE_MS,
  parameter int BLINK_LIM     = panel_pkg::BLINK_MS
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       hsel_i,
  input  wire logic [31:0]                haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [31:0]                hwdata_i,
  input  wire logic                       hready_i,
  output logic      [31:0]                hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  input  wire logic [panel_pkg::NKEY-1:0] keys_i,
  input  wire panel_pkg::proc_status_type proc_i,
  input  wire logic [15:0]                meas_temp_i,
  input  wire logic [15:0]                meas_current_i,
  input  wire logic [15:0]                meas_voltage_i,
  input  wire panel_pkg::xfer_src_type    xfer_i,
  output logic      [15:0]                meas_o,
  output panel_pkg::out_type              outputs_o,
  output panel_pkg::lamp_type             lamps_o,
  output panel_pkg::event_route_type      event_o,
  output logic                            ct_enable_o,
  output logic      [15:0]                transfer_o,
  output logic                            irq_o
);
  import panel_pkg::*;

  state_type r;
  state_type n;

  function automatic logic reached(input logic [15:0] c, input int lim);
    reached = int'({16'h0000, c}) >= lim - 1;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  function automatic logic [15:0] sat_dec(input logic [15:0] v);
    sat_dec = (v == 16'h0000) ? v : v - 16'h0001;
  endfunction

  function automatic logic route(input logic [ASSIGN_W-1:0] sel,
                                 input logic [FN_COUNT-1:0] fn);
    route = (int'({28'h0000000, sel}) < FN_COUNT) ? fn[sel] : 1'b0;
  endfunction

  function automatic logic [31:0] read_mux(input state_type s,
                                           input logic [7:0] a);
    case (a)
      CTRL_OFS:     read_mux = {21'h000000, s.ctrl};
      ASSIGN_OFS:   read_mux = {16'h0000, s.assign_map};
      XLO_OFS:      read_mux = {16'h0000, s.xlo};
      XHI_OFS:      read_mux = {16'h0000, s.xhi};
      STATUS_OFS:   read_mux = {16'h0000, s.param_idx, s.deb,
                                s.ready, s.menu, s.run_state == ST_RUN};
      VALUE_OFS:    read_mux = {16'h0000, s.value};
      IRQ_STAT_OFS: read_mux = {24'h000000, s.irq_stat};
      IRQ_MASK_OFS: read_mux = {24'h000000, s.irq_mask};
      XOUT_OFS:     read_mux = {16'h0000, s.transfer};
      default:      read_mux = 32'h00000000;
    endcase
  endfunction

  logic                tick;
  logic [NKEY-1:0]     press;
  logic [NKEY-1:0]     release_k;
  logic [IRQ_W-1:0]    ev;
  logic [IRQ_W-1:0]    clr;
  logic [FN_COUNT-1:0] fn;
  logic                pp;
  logic                hc;
  logic [15:0]         src;
  logic                src_ok;
  logic [15:0]         lo_c;
  logic [15:0]         hi_c;
  logic [15:0]         clamped;

  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    press = '0;
    release_k = '0;
    fn = proc_i.funcs;
    pp = r.ctrl[CTRL_PP_BIT];
    hc = r.ctrl[CTRL_HC_BIT];
    src = 16'h0000;
    src_ok = 1'b0;
    lo_c = 16'h0000;
    hi_c = 16'h0000;
    clamped = 16'h0000;

    // Millisecond prescaler
    tick = (int'(r.tick_cnt) >= TICK_CYCLES - 1);
    n.tick_cnt = tick ? 32'h00000000 : r.tick_cnt + 32'h00000001;

    // Bus write from the previous address phase
    if (r.wr_pend) begin
      case (r.wr_addr)
        CTRL_OFS:     n.ctrl = hwdata_i[10:0];
        ASSIGN_OFS:   n.assign_map = hwdata_i[15:0];
        XLO_OFS:      n.xlo = hwdata_i[15:0];
        XHI_OFS:      n.xhi = hwdata_i[15:0];
        VALUE_OFS:    n.value = hwdata_i[15:0];
        IRQ_STAT_OFS: clr = hwdata_i[IRQ_W-1:0];
        IRQ_MASK_OFS: n.irq_mask = hwdata_i[IRQ_W-1:0];
        default:      n.value = r.value;
      endcase
    end

    // Pin synchronisers and debounce
    n.s1 = keys_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int k = 0; k < NKEY; k++) begin
      if (r.s2[k] == r.s3[k] && r.s3[k] != r.deb[k]) begin
        if (tick) begin
          if (reached({8'h00, r.deb_ms[k]}, DEBOUNCE_LIM)) begin
            n.deb[k] = r.s3[k];
            n.deb_ms[k] = 8'h00;
          end else begin
            n.deb_ms[k] = r.deb_ms[k] + 8'h01;
          end
        end
      end else begin
        n.deb_ms[k] = 8'h00;
      end
    end
    press = n.deb & ~r.deb;
    release_k = ~n.deb & r.deb;

    // Run/reset key hold timing
    if (!r.deb[KEY_RUN]) begin
      n.run_ms = 16'h0000;
      n.run_done = 1'b0;
    end else if (!r.run_done) begin
      if (tick) begin
        n.run_ms = sat_inc(r.run_ms);
      end
      if (r.run_state == ST_RESET && reached(r.run_ms, RUN_HOLD_LIM)) begin
        n.run_state = ST_RUN;
        n.run_done = 1'b1;
        ev[IRQ_RUN] = 1'b1;
      end else if (r.run_state == ST_RUN &&
                   reached(r.run_ms, STOP_HOLD_LIM)) begin
        n.run_state = ST_RESET;
        n.run_done = 1'b1;
        ev[IRQ_STOP] = 1'b1;
      end
    end

    // Mode key: short press or long hold
    if (release_k[KEY_MODE] && !r.mode_done) begin
      n.param_idx = r.param_idx + 8'h01;
      n.menu = 1'b0;
      ev[IRQ_PARAM] = 1'b1;
    end
    if (!r.deb[KEY_MODE]) begin
      n.mode_ms = 16'h0000;
      n.mode_done = 1'b0;
    end else if (!r.mode_done) begin
      if (tick) begin
        n.mode_ms = sat_inc(r.mode_ms);
      end
      if (reached(r.mode_ms, MENU_HOLD_LIM)) begin
        n.menu = 1'b1;
        n.mode_done = 1'b1;
        ev[IRQ_MENU] = 1'b1;
      end
    end

    // Up and down keys
    if (press[KEY_UP]) begin
      n.value = sat_inc(n.value);
      ev[IRQ_UP] = 1'b1;
    end else if (press[KEY_DOWN]) begin
      n.value = sat_dec(n.value);
      ev[IRQ_DOWN] = 1'b1;
    end

    // Event input routing
    n.evr = '0;
    case (r.ctrl[CTRL_EVSEL_LSB +: 3])
      EV_RUN:  n.evr.run_reset = n.deb[KEY_EVENT];
      EV_AUTO: n.evr.auto_manual = n.deb[KEY_EVENT];
      EV_HOLD: n.evr.hold = n.deb[KEY_EVENT];
      EV_ADV:  n.evr.advance = n.deb[KEY_EVENT];
      EV_PAT:  n.evr.pattern = n.deb[KEY_EVENT];
      default: n.evr = '0;
    endcase
    if (press[KEY_EVENT] || release_k[KEY_EVENT]) begin
      ev[IRQ_EVENT] = 1'b1;
      if (r.ctrl[CTRL_EVSEL_LSB +: 3] == EV_RUN) begin
        n.run_state = press[KEY_EVENT] ? ST_RUN : ST_RESET;
      end
    end

    // Power-up output inhibit
    if (!r.ready && tick) begin
      if (reached(r.inhibit_ms, INHIBIT_LIM)) begin
        n.ready = 1'b1;
        ev[IRQ_READY] = 1'b1;
      end else begin
        n.inhibit_ms = sat_inc(r.inhibit_ms);
      end
    end

    // Autotune flash timer
    if (tick) begin
      if (reached(r.blink_ms, BLINK_LIM)) begin
        n.blink_ms = 16'h0000;
        n.blink = ~r.blink;
      end else begin
        n.blink_ms = sat_inc(r.blink_ms);
      end
    end

    // Output routing
    if (pp) begin
      fn[FN_HEAT] = 1'b0;
      fn[FN_COOL] = 1'b0;
      fn[FN_HBA] = 1'b0;
      fn[FN_LBA] = 1'b0;
    end
    if (pp) begin
      n.outs.ctrl1 = proc_i.valve_open;
      n.outs.ctrl2 = proc_i.valve_close;
    end else if (hc) begin
      n.outs.ctrl1 = fn[FN_HEAT];
      n.outs.ctrl2 = fn[FN_COOL];
    end else begin
      n.outs.ctrl1 = route(r.assign_map[0 +: ASSIGN_W], fn);
      n.outs.ctrl2 = route(r.assign_map[4 +: ASSIGN_W], fn);
    end
    n.outs.aux1 = route(r.assign_map[8 +: ASSIGN_W], fn);
    n.outs.aux2 = route(r.assign_map[12 +: ASSIGN_W], fn);
    if (!r.ready) begin
      n.outs = '0;
    end

    // Indicators
    n.lamps.primary_control_lamp = n.outs.ctrl1;
    n.lamps.secondary_control_lamp = n.outs.ctrl2;
    n.lamps.first_auxiliary_lamp = n.outs.aux1;
    n.lamps.second_auxiliary_lamp = n.outs.aux2;
    n.lamps.manual_lamp = proc_i.manual;
    n.lamps.reset_lamp = (n.run_state == ST_RESET);
    n.lamps.remote_lamp = proc_i.remote;
    n.lamps.autotune_lamp = proc_i.autotune & r.blink;
    n.lamps.hold_lamp = proc_i.hold;
    n.lamps.wait_lamp = proc_i.waiting;

    // Measurement source and current transformer enable
    case (r.ctrl[CTRL_INSEL_LSB +: 2])
      IN_CURRENT: n.meas = meas_current_i;
      IN_VOLTAGE: n.meas = meas_voltage_i;
      default:    n.meas = meas_temp_i;
    endcase
    n.ct_enable = ~r.ctrl[CTRL_LIN_BIT];

    // Transfer output source and scaling
    case (r.ctrl[CTRL_XSRC_LSB +: 3])
      XS_SP: begin
        src = xfer_i.sp;
        src_ok = 1'b1;
      end
      XS_PV: begin
        src = xfer_i.pv;
        src_ok = 1'b1;
      end
      XS_MVH: begin
        src = xfer_i.mv_heat;
        src_ok = ~pp;
      end
      XS_MVC: begin
        src = xfer_i.mv_cool;
        src_ok = ~pp;
      end
      XS_VALVE: begin
        src = xfer_i.valve;
        src_ok = pp;
      end
      default: begin
        src = 16'h0000;
        src_ok = 1'b0;
      end
    endcase
    lo_c = (r.xhi < r.xlo) ? r.xhi : r.xlo;
    hi_c = (r.xhi < r.xlo) ? r.xlo : r.xhi;
    clamped = (src < lo_c) ? lo_c : ((src > hi_c) ? hi_c : src);
    if (!src_ok) begin
      n.transfer = 16'h0000;
    end else if (r.xhi < r.xlo) begin
      n.transfer = r.xlo - clamped;
    end else begin
      n.transfer = clamped - r.xlo;
    end

    // Interrupt status: a new event wins over a clear
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    n.irq = |(n.irq_stat & n.irq_mask);

    // Bus address phase
    n.hreadyout = 1'b1;
    n.wr_pend = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      if (hwrite_i) begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr_i[7:0];
      end else begin
        n.hrdata = read_mux(r, haddr_i[7:0]);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.assign_map <= ASSIGN_RST;
      r.xlo <= XLO_RST;
      r.xhi <= XHI_RST;
      r.hreadyout <= 1'b1;
      r.ct_enable <= 1'b1;
      r.lamps.reset_lamp <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign hrdata_o = r.hrdata;
  assign hreadyout_o = r.hreadyout;
  assign hresp_o = 1'b0;
  assign meas_o = r.meas;
  assign outputs_o = r.outs;
  assign lamps_o = r.lamps;
  assign event_o = r.evr;
  assign ct_enable_o = r.ct_enable;
  assign transfer_o = r.transfer;
  assign irq_o = r.irq;

endmodule

`default_nettype wire

// ===== dv/panel_keys_output_router_properties.sv
// Checker for the panel key and output router, bound to its ports.
// Assumes ce_i stays high while autotune runs; reset is async, active high.
`timescale 1ns/1ps
`default_nettype none
module panel_keys_output_router_properties
  import panel_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int INHIBIT_LIM = 50,
  parameter int BLINK_LIM   = 5
) (
  input wire logic                       ref_clk_i,
  input wire logic                       rst_i,
  input wire logic                       ce_i,
  input wire logic                       hreadyout_o,
  input wire logic                       hresp_o,
  input wire panel_pkg::proc_status_type proc_i,
  input wire logic [15:0]                meas_temp_i,
  input wire logic [15:0]                meas_current_i,
  input wire logic [15:0]                meas_voltage_i,
  input wire logic [15:0]                meas_o,
  input wire panel_pkg::out_type         outputs_o,
  input wire panel_pkg::lamp_type        lamps_o,
  input wire panel_pkg::event_route_type event_o
);
  localparam int INHIB_SAFE = (INHIBIT_LIM - 1) * TICK_CYCLES;
  localparam int FLASH_MAX  = 2 * BLINK_LIM * TICK_CYCLES + 4;
  logic [31:0] up_q;

  // Cycles since reset release, saturating
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_q <= 32'h0;
    end else if (up_q < 32'(INHIB_SAFE)) begin
      up_q <= up_q + 32'h1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fresh;
    !$past(rst_i) && $past(ce_i);
  endsequence
  sequence s_at_lit;
    proc_i.autotune && lamps_o.autotune_lamp;
  endsequence

  property p_lamp_out;
    lamps_o.primary_control_lamp == outputs_o.ctrl1 &&
    lamps_o.secondary_control_lamp == outputs_o.ctrl2 &&
    lamps_o.first_auxiliary_lamp == outputs_o.aux1 &&
    lamps_o.second_auxiliary_lamp == outputs_o.aux2;
  endproperty
  property p_inhibit;
    up_q < 32'(INHIB_SAFE) |-> outputs_o == 4'h0;
  endproperty
  property p_manual;
    s_fresh |-> lamps_o.manual_lamp == $past(proc_i.manual) &&
      lamps_o.remote_lamp == $past(proc_i.remote);
  endproperty
  property p_hold_wait;
    s_fresh |-> lamps_o.hold_lamp == $past(proc_i.hold) &&
      lamps_o.wait_lamp == $past(proc_i.waiting);
  endproperty
  property p_at_gate;
    lamps_o.autotune_lamp |-> $past(proc_i.autotune);
  endproperty
  property p_at_flash;
    s_at_lit |-> ##[1:FLASH_MAX] !lamps_o.autotune_lamp;
  endproperty
  property p_meas;
    s_fresh |-> meas_o == $past(meas_temp_i) ||
      meas_o == $past(meas_current_i) || meas_o == $past(meas_voltage_i);
  endproperty
  property p_event;
    $onehot0(event_o);
  endproperty
  property p_okay;
    hresp_o == 1'b0 && hreadyout_o == 1'b1;
  endproperty

  a_lamp_out: assert property (p_lamp_out)
    else $error("output lamp differs from output");
  a_inhibit: assert property (p_inhibit)
    else $error("output active during power-up hold");
  a_manual: assert property (p_manual)
    else $error("manual or remote lamp wrong");
  a_hold_wait: assert property (p_hold_wait)
    else $error("hold or wait lamp wrong");
  a_at_gate: assert property (p_at_gate)
    else $error("autotune lamp lit without autotune");
  a_at_flash: assert property (p_at_flash)
    else $error("autotune lamp does not flash");
  a_meas: assert property (p_meas)
    else $error("measurement not from one source");
  a_event: assert property (p_event)
    else $error("event routed to several functions");
  a_okay: assert property (p_okay)
    else $error("bus response not ready okay");
endmodule

bind panel_keys_output_router panel_keys_output_router_properties #(
  .TICK_CYCLES(TICK_CYCLES), .INHIBIT_LIM(INHIBIT_LIM),
  .BLINK_LIM(BLINK_LIM)
) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .proc_i(proc_i),
  .meas_temp_i(meas_temp_i), .meas_current_i(meas_current_i),
  .meas_voltage_i(meas_voltage_i), .meas_o(meas_o),
  .outputs_o(outputs_o), .lamps_o(lamps_o), .event_o(event_o)
);
`default_nettype wire

// ===== dv/panel_operator.sv
// Operator model: presses front-panel keys for a set number of cycles.
// Assumes the key pins are active high; a released key reads low.
`timescale 1ns/1ps
`default_nettype none
module panel_operator
  import panel_pkg::*;
(
  input  wire logic                       clk_i,
  output logic      [panel_pkg::NKEY-1:0] keys_o
);
  initial keys_o = '0;
  task automatic set_key(input int k, input logic v);
    @(posedge clk_i);
    keys_o[k] <= v;
  endtask
  task automatic press(input int k, input int n);
    set_key(k, 1'b1);
    repeat (n) @(posedge clk_i);
    keys_o[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/panel_keys_output_router_tb_top.sv
// Self-checking bench for the panel key and output router.
// Assumes the operator model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module panel_keys_output_router_tb_top;
  import panel_pkg::*;
  logic            ref_clk_i = 1'b0;
  logic            rst_i     = 1'b1;
  logic            ce        = 1'b1;
  logic            hsel      = 1'b0;
  logic [31:0]     haddr     = 32'h0;
  logic [1:0]      htrans    = 2'h0;
  logic            hwrite    = 1'b0;
  logic [31:0]     hwdata    = 32'h0;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic [NKEY-1:0] keys;
  proc_status_type proc      = '0;
  xfer_src_type    xfer      = {16'h0096, 16'h00fa, 16'h015e, 16'h01c2,
                                16'h03e8};
  logic [15:0]     meas;
  out_type         outs;
  lamp_type        lamps;
  event_route_type evo;
  logic            cte;
  logic [15:0]     xout;
  logic            irq;
  logic [31:0]     q;
  int              err_total    = 0;
  int              total_checks = 0;
  int              cyc          = 0;
  logic [7:0]      ra [5] = '{CTRL_OFS, ASSIGN_OFS, XLO_OFS, XHI_OFS, 8'h24};
  logic [31:0]     rv [5] = '{32'h0, 32'h4320, 32'h0, 32'hffff, 32'h0};
  logic [15:0]     xe [2][5] = '{'{16'h0032, 16'h0096, 16'h00fa, 16'h015e,
    16'h0000}, '{16'h0032, 16'h0096, 16'h0000, 16'h0000, 16'h0190}};
  int              rn [4] = '{20, 56, 48, 8100};
  int              mn [4] = '{3, 16, 4100, 16};
  logic [31:0]     ms [4] = '{32'h0, 32'h100, 32'h102, 32'h200};

  always #5 ref_clk_i = ~ref_clk_i;

  panel_operator op (.clk_i(ref_clk_i), .keys_o(keys));

  panel_keys_output_router #(.TICK_CYCLES(4), .RUN_HOLD_LIM(10),
    .DEBOUNCE_LIM(2), .BLINK_LIM(5)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(), .keys_i(keys), .proc_i(proc),
    .meas_temp_i(xfer.sp), .meas_current_i(xfer.pv),
    .meas_voltage_i(xfer.mv_heat), .xfer_i(xfer), .meas_o(meas),
    .outputs_o(outs), .lamps_o(lamps), .event_o(evo), .ct_enable_o(cte),
    .transfer_o(xout), .irq_o(irq));

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk_i);
    while (hreadyout !== 1'b1) @(posedge ref_clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk_i);
    while (hreadyout !== 1'b1) @(posedge ref_clk_i);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    wait_n(3);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0, q);
      chk(q, rv[i]);
    end
    proc.funcs <= '1;
    wait_n(100);
    chk({28'h0, outs}, 32'h0);
    wait_n(20000);
    chk({28'h0, outs}, 32'hf);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 14; k++) begin
      wr(ASSIGN_OFS, {16'h0, {4{4'(k)}}});
      proc.funcs <= 13'(1 << k);
      wait_n(3);
      chk({28'h0, outs}, (k < 13) ? 32'hf : 32'h0);
      proc.funcs <= ~13'(1 << k);
      wait_n(3);
      chk({28'h0, outs}, 32'h0);
    end
    wr(CTRL_OFS, 32'h2);
    wr(ASSIGN_OFS, 32'hdddd);
    proc.funcs <= 13'h1;
    wait_n(3);
    chk({28'h0, outs}, 32'h8);
    proc.funcs <= 13'h2;
    wait_n(3);
    chk({28'h0, outs}, 32'h4);
    wr(CTRL_OFS, 32'h1);
    wr(ASSIGN_OFS, 32'h2600);
    proc.funcs <= '1;
    proc.valve_open <= 1'b1;
    wait_n(3);
    chk({28'h0, outs}, 32'h9);
    proc.funcs <= 13'h63;
    proc.valve_open <= 1'b0;
    proc.valve_close <= 1'b1;
    wait_n(3);
    chk({28'h0, outs}, 32'h4);
    wr(CTRL_OFS, 32'h4);
    wait_n(3);
    chk({31'h0, cte}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_OFS, 32'(s << 3));
      wait_n(3);
      chk({16'h0, meas}, (s == 1) ? 32'h00fa :
          (s == 2) ? 32'h015e : 32'h0096);
    end
    chk({31'h0, cte}, 32'h1);
    wr(XLO_OFS, 32'h64);
    wr(XHI_OFS, 32'h1f4);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 5; s++) begin
        wr(CTRL_OFS, 32'((s << 8) | p));
        wait_n(3);
        chk({16'h0, xout}, {16'h0, xe[p][s]});
      end
    end
    wr(XLO_OFS, 32'h1f4);
    wr(XHI_OFS, 32'h64);
    wr(CTRL_OFS, 32'h0);
    wait_n(3);
    chk({16'h0, xout}, 32'h15e);
    wr(IRQ_MASK_OFS, 32'h1);
    for (int i = 0; i < 4; i++) begin
      op.press(KEY_RUN, rn[i]);
      wait_n(20);
      chk({31'h0, lamps.reset_lamp}, {31'h0, i == 0 || i == 3});
      if (i == 1) begin
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_OFS, 32'h1);
        wait_n(3);
        chk({31'h0, irq}, 32'h0);
      end
    end
    for (int i = 0; i < 4; i++) begin
      op.press(KEY_MODE, mn[i]);
      wait_n(20);
      bus(1'b0, STATUS_OFS, 32'h0, q);
      chk(q & 32'hff02, ms[i]);
    end
    wr(VALUE_OFS, 32'h64);
    for (int i = 0; i < 4; i++) begin
      ce <= (i < 3);
      op.press((i < 2) ? KEY_UP : KEY_DOWN, 16);
      wait_n(20);
    end
    ce <= 1'b1;
    bus(1'b0, VALUE_OFS, 32'h0, q);
    chk(q, 32'h65);
    proc.manual <= 1'b1;
    proc.remote <= 1'b1;
    proc.hold <= 1'b1;
    proc.waiting <= 1'b1;
    proc.autotune <= 1'b1;
    wait_n(60);
    chk({22'h0, lamps} & 32'h2b, 32'h2b);
    for (int e = 0; e < 5; e++) begin
      wr(CTRL_OFS, 32'(e << 5));
      op.set_key(KEY_EVENT, 1'b1);
      wait_n(20);
      chk({27'h0, evo}, 32'h10 >> e);
      op.set_key(KEY_EVENT, 1'b0);
      wait_n(20);
    end
    end_sim();
  end
endmodule
`default_nettype wire
